/* File: hw/rstd_core.sv */
// receive status reporting and transmit local-dma setup behind an APB slave
// assumes receiver, fifo and dma inputs are synchronous to pclk
`timescale 1ns/1ps

module rstd_core
    import rstd_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [RSTD_ADDR_W-1:0] paddr,
    input wire logic [RSTD_DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [RSTD_DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rx_frame_start,
    input wire logic rx_frame_end,
    input wire rstd_rx_end_type rx_end_info,
    input wire logic rx_fifo_overflow,
    input wire logic codec_carrier,
    input wire logic codec_collision,
    input wire logic jabber_collision,
    output logic rx_store,
    output logic rx_abort,
    output logic status_wr_valid,
    output logic [7:0] status_wr_data,
    input wire logic status_wr_ready,
    input wire logic tx_byte_moved,
    output rstd_tx_dma_type tx_dma,
    output logic tx_done
);

    // register file state
    logic [7:0] receive_status, next_receive_status;
    logic [7:0] transmit_page_start, next_transmit_page_start;
    logic [7:0] transmit_byte_count_low, next_transmit_byte_count_low;
    logic [7:0] transmit_byte_count_high, next_transmit_byte_count_high;
    logic save_errored_packets, next_save_errored_packets;
    logic monitor_mode, next_monitor_mode;
    logic [7:0] alignment_error_tally, next_alignment_error_tally;
    logic [7:0] crc_error_tally, next_crc_error_tally;
    logic [7:0] missed_packet_tally, next_missed_packet_tally;
    logic [RSTD_DATA_W-1:0] next_prdata;
    logic next_pready, next_pslverr;

    // receive path state
    rstd_rx_state_type rx_state, next_rx_state;
    logic next_rx_store, next_rx_abort;
    logic next_status_wr_valid;
    logic [7:0] next_status_wr_data;

    // transmit path state
    rstd_tx_state_type tx_state, next_tx_state;
    rstd_tx_dma_type next_tx_dma;
    logic next_tx_done;

    logic wr_take;
    logic tx_go;
    logic crc_err, align_err, errored, missed, keep_pkt;

    function automatic logic [7:0] tally_step(input logic [7:0] value, input logic hit);
        // saturate so a slow host still sees that errors happened
        tally_step = (hit && value != RSTD_TALLY_MAX) ? value + 8'h01 : value;
    endfunction

    function automatic logic mapped(input logic [7:0] addr);
        unique case (addr)
            RSTD_ADDR_RX_STATUS, RSTD_ADDR_TX_PAGE, RSTD_ADDR_TX_COUNT_LO,
            RSTD_ADDR_TX_COUNT_HI, RSTD_ADDR_RX_CONTROL, RSTD_ADDR_TALLY_ALIGN,
            RSTD_ADDR_TALLY_CRC, RSTD_ADDR_TALLY_MISSED, RSTD_ADDR_TX_COMMAND,
            RSTD_ADDR_TX_ADDR_LO, RSTD_ADDR_TX_ADDR_HI, RSTD_ADDR_TX_LEFT_LO,
            RSTD_ADDR_TX_LEFT_HI: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    endfunction

    // write lands at the access edge where pready is already high
    assign wr_take = psel && penable && pready && pwrite && pstrb[0] && mapped(paddr);
    assign tx_go = wr_take && paddr == RSTD_ADDR_TX_COMMAND && pwdata[RSTD_TC_START]
        && tx_state == RSTD_TX_IDLE && {transmit_byte_count_high, transmit_byte_count_low} != 16'h0000;

    // frame classification, only meaningful on rx_frame_end
    assign crc_err = rx_end_info.crc_bad;
    assign align_err = rx_end_info.crc_bad && rx_end_info.off_boundary;
    assign errored = crc_err;
    assign missed = rx_end_info.addr_match && (rx_end_info.no_buffer || monitor_mode);
    assign keep_pkt = rx_end_info.addr_match && !rx_end_info.no_buffer && !monitor_mode
        && (!errored || save_errored_packets);

    // apb slave: no wait state; read data comes from a flop loaded at the setup edge
    always_comb begin
        next_pready = psel && !penable;
        next_pslverr = 1'b0;
        next_prdata = prdata;
        if (psel && !penable) begin
            next_prdata = RSTD_RDATA_RESET;
            next_pslverr = !mapped(paddr);
            unique case (paddr)
                RSTD_ADDR_RX_STATUS: next_prdata[7:0] = receive_status;
                RSTD_ADDR_TX_PAGE: next_prdata[7:0] = transmit_page_start;
                RSTD_ADDR_TX_COUNT_LO: next_prdata[7:0] = transmit_byte_count_low;
                RSTD_ADDR_TX_COUNT_HI: next_prdata[7:0] = transmit_byte_count_high;
                RSTD_ADDR_RX_CONTROL: begin
                    next_prdata[RSTD_RC_SAVE_ERR] = save_errored_packets;
                    next_prdata[RSTD_RC_MONITOR] = monitor_mode;
                end
                RSTD_ADDR_TALLY_ALIGN: next_prdata[7:0] = alignment_error_tally;
                RSTD_ADDR_TALLY_CRC: next_prdata[7:0] = crc_error_tally;
                RSTD_ADDR_TALLY_MISSED: next_prdata[7:0] = missed_packet_tally;
                RSTD_ADDR_TX_COMMAND: next_prdata[RSTD_TC_BUSY] = tx_dma.active;
                RSTD_ADDR_TX_ADDR_LO: next_prdata[7:0] = tx_dma.addr[7:0];
                RSTD_ADDR_TX_ADDR_HI: next_prdata[7:0] = tx_dma.addr[15:8];
                RSTD_ADDR_TX_LEFT_LO: next_prdata[7:0] = tx_dma.remaining[7:0];
                RSTD_ADDR_TX_LEFT_HI: next_prdata[7:0] = tx_dma.remaining[15:8];
                default: next_prdata = RSTD_RDATA_RESET;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= RSTD_RDATA_RESET;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // software-written configuration
    always_comb begin
        next_transmit_page_start = transmit_page_start;
        next_transmit_byte_count_low = transmit_byte_count_low;
        next_transmit_byte_count_high = transmit_byte_count_high;
        next_save_errored_packets = save_errored_packets;
        next_monitor_mode = monitor_mode;
        if (wr_take) begin
            unique case (paddr)
                RSTD_ADDR_TX_PAGE: next_transmit_page_start = pwdata[7:0];
                RSTD_ADDR_TX_COUNT_LO: next_transmit_byte_count_low = pwdata[7:0];
                RSTD_ADDR_TX_COUNT_HI: next_transmit_byte_count_high = pwdata[7:0];
                RSTD_ADDR_RX_CONTROL: begin
                    next_save_errored_packets = pwdata[RSTD_RC_SAVE_ERR];
                    next_monitor_mode = pwdata[RSTD_RC_MONITOR];
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            transmit_page_start <= RSTD_BYTE_RESET;
            transmit_byte_count_low <= RSTD_BYTE_RESET;
            transmit_byte_count_high <= RSTD_BYTE_RESET;
            save_errored_packets <= 1'b0;
            monitor_mode <= 1'b0;
        end else begin
            transmit_page_start <= next_transmit_page_start;
            transmit_byte_count_low <= next_transmit_byte_count_low;
            transmit_byte_count_high <= next_transmit_byte_count_high;
            save_errored_packets <= next_save_errored_packets;
            monitor_mode <= next_monitor_mode;
        end
    end

    // receive status, tallies and status write to the local dma
    always_comb begin
        next_rx_state = rx_state;
        next_receive_status = receive_status;
        next_alignment_error_tally = alignment_error_tally;
        next_crc_error_tally = crc_error_tally;
        next_missed_packet_tally = missed_packet_tally;
        next_rx_store = 1'b0;
        next_rx_abort = 1'b0;
        next_status_wr_valid = status_wr_valid && !status_wr_ready;
        next_status_wr_data = status_wr_data;
        unique case (rx_state)
            RSTD_RX_IDLE: begin
                if (rx_frame_start) begin
                    next_receive_status[5:0] = 6'h00;
                    next_rx_state = RSTD_RX_RECV;
                end
            end
            RSTD_RX_RECV: begin
                if (rx_fifo_overflow) begin
                    next_receive_status[RSTD_RS_OVERFLOW] = 1'b1;
                    next_rx_abort = 1'b1;
                    next_rx_state = RSTD_RX_IDLE;
                end else if (rx_frame_end) begin
                    next_receive_status[RSTD_RS_CRC] = crc_err;
                    next_receive_status[RSTD_RS_ALIGN] = align_err;
                    next_receive_status[RSTD_RS_MISSED] = missed;
                    next_receive_status[RSTD_RS_MULTICAST] = rx_end_info.multicast;
                    next_receive_status[RSTD_RS_INTACT] = !crc_err && !missed;
                    next_crc_error_tally = tally_step(crc_error_tally, crc_err);
                    next_alignment_error_tally = tally_step(alignment_error_tally, align_err);
                    next_missed_packet_tally = tally_step(missed_packet_tally, missed);
                    if (keep_pkt) begin
                        // a pending byte is replaced: the newer frame owns the dma slot
                        next_rx_store = 1'b1;
                        next_status_wr_valid = 1'b1;
                        next_status_wr_data = {receive_status[7:6], rx_end_info.multicast,
                            missed, 1'b0, align_err, crc_err, !crc_err && !missed};
                    end
                    next_rx_state = RSTD_RX_IDLE;
                end
            end
        endcase
        next_receive_status[RSTD_RS_DISABLED] = monitor_mode;
        next_receive_status[RSTD_RS_DEFER] = codec_carrier || codec_collision
            || jabber_collision;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_state <= RSTD_RX_IDLE;
            receive_status <= RSTD_BYTE_RESET;
            alignment_error_tally <= RSTD_BYTE_RESET;
            crc_error_tally <= RSTD_BYTE_RESET;
            missed_packet_tally <= RSTD_BYTE_RESET;
            rx_store <= 1'b0;
            rx_abort <= 1'b0;
            status_wr_valid <= 1'b0;
            status_wr_data <= RSTD_BYTE_RESET;
        end else begin
            rx_state <= next_rx_state;
            receive_status <= next_receive_status;
            alignment_error_tally <= next_alignment_error_tally;
            crc_error_tally <= next_crc_error_tally;
            missed_packet_tally <= next_missed_packet_tally;
            rx_store <= next_rx_store;
            rx_abort <= next_rx_abort;
            status_wr_valid <= next_status_wr_valid;
            status_wr_data <= next_status_wr_data;
        end
    end

    // transmit local dma channel
    always_comb begin
        next_tx_state = tx_state;
        next_tx_dma = tx_dma;
        next_tx_done = 1'b0;
        unique case (tx_state)
            RSTD_TX_IDLE: begin
                if (tx_go) begin
                    next_tx_dma.addr = {transmit_page_start, 8'h00};
                    // full 16-bit length, nothing capped at frame size
                    next_tx_dma.remaining = {transmit_byte_count_high,
                        transmit_byte_count_low};
                    next_tx_dma.active = 1'b1;
                    next_tx_state = RSTD_TX_MOVE;
                end
            end
            RSTD_TX_MOVE: begin
                if (tx_byte_moved) begin
                    next_tx_dma.addr = tx_dma.addr + 16'h0001;
                    next_tx_dma.remaining = tx_dma.remaining - 16'h0001;
                    if (tx_dma.remaining == 16'h0001) begin
                        next_tx_dma.active = 1'b0;
                        next_tx_done = 1'b1;
                        next_tx_state = RSTD_TX_IDLE;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_state <= RSTD_TX_IDLE;
            tx_dma <= '0;
            tx_done <= 1'b0;
        end else begin
            tx_state <= next_tx_state;
            tx_dma <= next_tx_dma;
            tx_done <= next_tx_done;
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_frame_end_in_recv;
        rx_state == RSTD_RX_RECV && !rx_fifo_overflow && rx_frame_end;
    endsequence

    sequence s_tx_loaded;
        tx_dma.active && tx_dma.addr[7:0] == 8'h00;
    endsequence

    AST_GOOD_STATUS_WRITTEN: assert property (
        s_frame_end_in_recv and (keep_pkt && !crc_err) |=> status_wr_valid && status_wr_data[0]
    ) else $error("good stored packet did not raise a status write");

    AST_ERRORED_KEPT: assert property (
        s_frame_end_in_recv and (keep_pkt && crc_err) |=> status_wr_valid && status_wr_data[1]
            && rx_store
    ) else $error("kept errored packet lacks its status write");

    AST_ERRORED_DROPPED: assert property (
        s_frame_end_in_recv and (crc_err && !save_errored_packets) |=> !rx_store
    ) else $error("errored packet stored while discarding is set");

    AST_CLEAR_ON_ARRIVAL: assert property (
        rx_state == RSTD_RX_IDLE && rx_frame_start |=> receive_status[5:0] == 6'h00
    ) else $error("status not cleared at packet arrival");

    AST_INTACT_MEANS_CLEAN: assert property (
        receive_status[RSTD_RS_INTACT] |-> receive_status[4:1] == 4'h0
    ) else $error("intact bit set beside an error flag");

    AST_CRC_TALLY_STEPS: assert property (
        s_frame_end_in_recv and (crc_err && crc_error_tally != RSTD_TALLY_MAX)
            |=> crc_error_tally == $past(crc_error_tally) + 8'h01
    ) else $error("crc tally did not step");

    AST_ALIGN_NEVER_ALONE: assert property (
        receive_status[RSTD_RS_ALIGN] |-> receive_status[RSTD_RS_CRC]
    ) else $error("alignment flag without crc flag");

    AST_OVERFLOW_ABORTS: assert property (
        rx_state == RSTD_RX_RECV && rx_fifo_overflow |=> rx_abort
            && receive_status[RSTD_RS_OVERFLOW] && rx_state == RSTD_RX_IDLE && !rx_store
    ) else $error("fifo overflow did not abort the packet");

    AST_MISSED_COUNTED: assert property (
        s_frame_end_in_recv and (missed && missed_packet_tally != RSTD_TALLY_MAX)
            |=> receive_status[RSTD_RS_MISSED]
            && missed_packet_tally == $past(missed_packet_tally) + 8'h01
    ) else $error("missed packet not flagged and counted");

    AST_MONITOR_NO_BUFFER: assert property (
        s_frame_end_in_recv and monitor_mode |=> !rx_store
    ) else $error("packet buffered in monitor mode");

    AST_DISABLED_FOLLOWS: assert property (
        1'b1 |=> receive_status[RSTD_RS_DISABLED] == $past(monitor_mode)
    ) else $error("disabled bit not set in monitor mode");

    AST_TX_LOAD: assert property (
        tx_go |=> s_tx_loaded ##0 tx_dma.addr[15:8] == $past(transmit_page_start)
    ) else $error("transmit start did not load page address");

    AST_TX_DECREMENT: assert property (
        tx_state == RSTD_TX_MOVE && tx_byte_moved
            |=> tx_dma.remaining == $past(tx_dma.remaining) - 16'h0001
    ) else $error("transmit length did not decrement");

endmodule

/* File: hw/rstd_pkg.sv */
// package for the receive-status and transmit-dma-setup block
// assumes an APB slave with 8-bit byte addresses and 32-bit data
package rstd_pkg;

    localparam int RSTD_ADDR_W = 8;
    localparam int RSTD_DATA_W = 32;

    // register byte addresses (one aligned word each)
    localparam logic [7:0] RSTD_ADDR_RX_STATUS = 8'h0C;
    localparam logic [7:0] RSTD_ADDR_TX_PAGE = 8'h20;
    localparam logic [7:0] RSTD_ADDR_TX_COUNT_LO = 8'h24;
    localparam logic [7:0] RSTD_ADDR_TX_COUNT_HI = 8'h28;
    localparam logic [7:0] RSTD_ADDR_RX_CONTROL = 8'h2C;
    localparam logic [7:0] RSTD_ADDR_TALLY_ALIGN = 8'h30;
    localparam logic [7:0] RSTD_ADDR_TALLY_CRC = 8'h34;
    localparam logic [7:0] RSTD_ADDR_TALLY_MISSED = 8'h38;
    localparam logic [7:0] RSTD_ADDR_TX_COMMAND = 8'h40;
    localparam logic [7:0] RSTD_ADDR_TX_ADDR_LO = 8'h44;
    localparam logic [7:0] RSTD_ADDR_TX_ADDR_HI = 8'h48;
    localparam logic [7:0] RSTD_ADDR_TX_LEFT_LO = 8'h4C;
    localparam logic [7:0] RSTD_ADDR_TX_LEFT_HI = 8'h50;

    // receive status fields
    localparam int RSTD_RS_INTACT = 0;
    localparam int RSTD_RS_CRC = 1;
    localparam int RSTD_RS_ALIGN = 2;
    localparam int RSTD_RS_OVERFLOW = 3;
    localparam int RSTD_RS_MISSED = 4;
    localparam int RSTD_RS_MULTICAST = 5;
    localparam int RSTD_RS_DISABLED = 6;
    localparam int RSTD_RS_DEFER = 7;

    // receive control fields
    localparam int RSTD_RC_SAVE_ERR = 0;
    localparam int RSTD_RC_MONITOR = 1;

    // transmit command fields
    localparam int RSTD_TC_START = 0;
    localparam int RSTD_TC_BUSY = 1;

    localparam logic [7:0] RSTD_BYTE_RESET = 8'h00;
    localparam logic [7:0] RSTD_TALLY_MAX = 8'hFF;
    localparam logic [15:0] RSTD_WORD_RESET = 16'h0000;
    localparam logic [31:0] RSTD_RDATA_RESET = 32'h0000_0000;

    // what the receiver reports at the end of a frame
    typedef struct packed {
        logic crc_bad;
        logic off_boundary;
        logic multicast;
        logic addr_match;
        logic no_buffer;
    } rstd_rx_end_type;

    // local dma view of the transmit channel
    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] remaining;
        logic active;
    } rstd_tx_dma_type;

    typedef enum logic {
        RSTD_RX_IDLE = 1'b0,
        RSTD_RX_RECV = 1'b1
    } rstd_rx_state_type;

    typedef enum logic {
        RSTD_TX_IDLE = 1'b0,
        RSTD_TX_MOVE = 1'b1
    } rstd_tx_state_type;

endpackage

/* File: tb/rstd_partner.sv */
// local dma and buffer memory stand-in for the status and transmit paths
// assumes pclk domain; status writes may be stalled two cycles
`timescale 1ns/1ps
module rstd_partner
    import rstd_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic slow,
    input wire logic status_wr_valid,
    input wire logic [7:0] status_wr_data,
    input wire rstd_tx_dma_type tx_dma,
    output logic status_wr_ready,
    output logic tx_byte_moved,
    output logic [7:0] last_status,
    output int stored
);
    logic [1:0] stall;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_wr_ready <= 1'b0;
            tx_byte_moved <= 1'b0;
            last_status <= 8'h00;
            stored <= 0;
            stall <= 2'h0;
        end else begin
            if (status_wr_valid && !status_wr_ready) begin
                status_wr_ready <= (stall == 2'h0);
                stall <= stall - 2'h1;
            end else begin
                status_wr_ready <= 1'b0;
                stall <= slow ? 2'h2 : 2'h0;
            end
            if (status_wr_valid && status_wr_ready) begin
                last_status <= status_wr_data;
                stored <= stored + 1;
            end
            // a byte every other cycle, so the fifo side lags the bus
            tx_byte_moved <= tx_dma.active && !tx_byte_moved;
        end
    end
endmodule

/* File: tb/rx_status_and_tx_dma_setup_test.sv */
// bench for the receive status and transmit dma setup block
// assumes the partner answers status writes and moves transmit bytes
`timescale 1ns/1ps
module rx_status_and_tx_dma_setup_test
    import rstd_pkg::*;
;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slow = 0;
    logic rx_frame_start = 0, rx_frame_end = 0, rx_fifo_overflow = 0, codec_carrier = 0;
    logic codec_collision = 0, jabber_collision = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd_data;
    logic [4:0] rx_end_info = 5'h00;
    logic pready, pslverr, rx_store, rx_abort, status_wr_valid, status_wr_ready;
    logic tx_byte_moved, tx_done, rd_err, st, ab;
    logic [7:0] status_wr_data, last_status;
    rstd_tx_dma_type tx_dma;
    int stored, failures = 0, checked = 0, cycles = 0;
    logic [1:0] ctl [7] = '{2'h0, 2'h0, 2'h1, 2'h0, 2'h0, 2'h0, 2'h2};
    logic [4:0] inf [7] = '{5'h02, 5'h12, 5'h1a, 5'h06, 5'h02, 5'h03, 5'h02};
    logic [7:0] exp_st [7] = '{8'h01, 8'h02, 8'h06, 8'h21, 8'h08, 8'h10, 8'h50};
    logic sto [7] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};

    rstd_core u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rx_frame_start(rx_frame_start),
        .rx_frame_end(rx_frame_end), .rx_end_info(rx_end_info),
        .rx_fifo_overflow(rx_fifo_overflow), .codec_carrier(codec_carrier),
        .codec_collision(codec_collision), .jabber_collision(jabber_collision),
        .rx_store(rx_store),
        .rx_abort(rx_abort), .status_wr_valid(status_wr_valid),
        .status_wr_data(status_wr_data), .status_wr_ready(status_wr_ready),
        .tx_byte_moved(tx_byte_moved), .tx_dma(tx_dma), .tx_done(tx_done));
    rstd_partner u_mem (.pclk(pclk), .presetn(presetn), .slow(slow),
        .status_wr_valid(status_wr_valid), .status_wr_data(status_wr_data), .tx_dma(tx_dma),
        .status_wr_ready(status_wr_ready), .tx_byte_moved(tx_byte_moved),
        .last_status(last_status), .stored(stored));

    initial begin
        forever #12.5 pclk = ~pclk;
    end

    task end_of_test();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            end_of_test();
        end
    end

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask

    // extra idle edge at the end keeps two calls from driving one time step
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd_data = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
        apb(1'b0, a, 8'h00);
        chk(n, {24'h00_0000, e}, rd_data);
    endtask

    task automatic frame(input logic [1:0] c, input logic [4:0] f, input logic ovf, input logic s);
        apb(1'b1, RSTD_ADDR_RX_CONTROL, {6'h00, c});
        slow <= s;
        rx_frame_start <= 1'b1;
        @(posedge pclk);
        rx_frame_start <= 1'b0;
        rx_fifo_overflow <= ovf;
        rx_frame_end <= !ovf;
        rx_end_info <= f;
        @(posedge pclk);
        rx_fifo_overflow <= 1'b0;
        rx_frame_end <= 1'b0;
        #1;
        st = rx_store;
        ab = rx_abort;
        repeat (6) @(posedge pclk);
    endtask

    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(RSTD_ADDR_TX_PAGE, 8'h00, "tx_page_reset");
        rd(8'h04, 8'h00, "unmapped_data");
        chk("unmapped_err", 1'b1, rd_err);
        for (int i = 0; i < 7; i++) begin
            frame(ctl[i], inf[i], i == 4, i[0]);
            chk("rx_store", sto[i], st);
            chk("rx_abort", i == 4, ab);
            rd(RSTD_ADDR_RX_STATUS, exp_st[i], "status");
            if (sto[i]) begin
                chk("status_in_memory", exp_st[i], last_status);
            end
        end
        chk("stores", 32'h0000_0003, stored);
        apb(1'b1, RSTD_ADDR_RX_CONTROL, 8'h00);
        rd(RSTD_ADDR_RX_STATUS, 8'h10, "status_monitor_off");
        // status bit 7 follows the line one edge later; read data is taken at setup
        codec_carrier <= 1'b1;
        @(posedge pclk);
        rd(RSTD_ADDR_RX_STATUS, 8'h90, "status_carrier");
        codec_carrier <= 1'b0;
        jabber_collision <= 1'b1;
        @(posedge pclk);
        rd(RSTD_ADDR_RX_STATUS, 8'h90, "status_jabber");
        jabber_collision <= 1'b0;
        codec_collision <= 1'b1;
        @(posedge pclk);
        rd(RSTD_ADDR_RX_STATUS, 8'h90, "status_collision");
        codec_collision <= 1'b0;
        @(posedge pclk);
        rd(RSTD_ADDR_RX_STATUS, 8'h10, "status_quiet");
        apb(1'b1, RSTD_ADDR_TALLY_CRC, 8'hff);
        rd(RSTD_ADDR_TALLY_ALIGN, 8'h01, "align_tally");
        rd(RSTD_ADDR_TALLY_CRC, 8'h02, "crc_tally");
        rd(RSTD_ADDR_TALLY_MISSED, 8'h02, "missed_tally");
        apb(1'b1, RSTD_ADDR_TX_PAGE, 8'h12);
        apb(1'b1, RSTD_ADDR_TX_COUNT_LO, 8'h02);
        apb(1'b1, RSTD_ADDR_TX_COUNT_HI, 8'h01);
        apb(1'b1, RSTD_ADDR_TX_COMMAND, 8'h01);
        #1;
        chk("tx_start_addr", 32'h0000_1200, tx_dma.addr);
        chk("tx_start_left", 32'h0000_0102, tx_dma.remaining);
        chk("tx_start_active", 32'h0000_0001, tx_dma.active);
        for (int n = 0; n < 2000 && tx_done !== 1'b1; n++) begin
            @(posedge pclk);
            #1;
        end
        chk("tx_done", 1'b1, tx_done);
        chk("tx_end_addr", 32'h0000_1302, tx_dma.addr);
        chk("tx_end_left", 32'h0000_0000, tx_dma.remaining);
        chk("tx_end_active", 32'h0000_0000, tx_dma.active);
        rd(RSTD_ADDR_TX_COUNT_LO, 8'h02, "count_low");
        rd(RSTD_ADDR_TX_COUNT_HI, 8'h01, "count_high");
        end_of_test();
    end
endmodule
